/* logic/ring_val_cfg.svh */
// Register map, field positions and timing constants for ring validation
// Functional notes
// - After qualification wait 256 ms times the 3-bit delay code before reporting.
// - Ringing ends 128 ms times the timeout code after the last threshold event.
// - Signal must meet frequency bounds for the qualification interval before valid.
// - Enable low bypasses validation; enable high validates in every operating mode.
// - Every event during qualification reloads the assertion timer, which counts down.
// - An event after the timer expired means frequency too low; ring invalidated.
// - Assertion minus max-frequency field gives minimum event spacing in 2 ms steps.
// - Timer above the max-frequency field at a later event means frequency too high.
`ifndef RING_VAL_CFG_SVH
`define RING_VAL_CFG_SVH

// ----------------------------------------------------------------------
// Register indices; byte address is four times the index
// ----------------------------------------------------------------------
`define RV_IDX_CTRL2 6'h17
`define RV_IDX_CTRL3 6'h18
`define RV_IDX_AUX 6'h20
`define RV_IDX_STAT 6'h21

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RV_CTRL2_RST 8'h2d
`define RV_CTRL3_RST 8'h19
`define RV_AUX_RST 8'h0d

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define RV_DLY_HI_BIT 7
`define RV_TO_MSB 6
`define RV_TO_LSB 3
`define RV_QI_MSB 2
`define RV_EN_BIT 7
`define RV_RES_BIT 6
`define RV_AS_MSB 5
`define RV_AUX_DLY_MSB 7
`define RV_AUX_DLY_LSB 6
`define RV_MX_MSB 5
`define RV_ST_VALID 0
`define RV_ST_LOW 1
`define RV_ST_HIGH 2
`define RV_ST_BUSY 3

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define RV_CLK_PERIOD_NS 50
`define RV_TICK_NS 2000000
`define RV_TICK_MS 2
`define RV_DELAY_STEP_MS 256
`define RV_TIMEOUT_STEP_MS 128
`define RV_QUAL_STEP_MS 128

`endif

/* logic/ring_val_pkg.sv */
// Types shared by the ring validation logic
package ring_val_pkg;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_QUAL,
		ST_DELAY,
		ST_VALID
	} ring_state_t;
endpackage : ring_val_pkg

/* logic/ring_validation_logic.sv */
// Ring validation logic with classic Wishbone register slave
`timescale 1ns/100ps
`include "ring_val_cfg.svh"

module ring_validation_logic
	import ring_val_pkg::*;
#(
	parameter int TICK_CYCLES = `RV_TICK_NS / `RV_CLK_PERIOD_NS
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic ring_event_i,
	output logic ring_valid_o
);

	// ------------------------------------------------------------------
	// Decoding
	// ------------------------------------------------------------------
	function automatic logic reg_hit(input logic [7:0] adr, input logic [5:0] idx);
		reg_hit = (adr[7:2] == idx);
	endfunction : reg_hit

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	logic [7:0] ctrl2;
	logic [7:0] ctrl3;
	logic [7:0] aux;
	logic [7:0] next_ctrl2;
	logic [7:0] next_ctrl3;
	logic [7:0] next_aux;
	logic [31:0] next_dat;
	logic next_ack;
	logic [7:0] rd_byte;
	logic access;
	logic wr_en;

	logic sync1;
	logic sync2;
	logic sync3;
	logic ev;

	ring_state_t state;
	ring_state_t next_state;
	logic [15:0] pre;
	logic [15:0] next_pre;
	logic tick;
	logic [5:0] qtimer;
	logic [5:0] next_qtimer;
	logic [9:0] phase;
	logic [9:0] next_phase;
	logic [9:0] idle_cnt;
	logic [9:0] next_idle_cnt;
	logic ring_valid;
	logic next_ring_valid;
	logic too_low;
	logic too_high;
	logic next_too_low;
	logic next_too_high;

	logic enable;
	logic [5:0] ras;
	logic [5:0] max_frequency_bound;
	logic [2:0] delay_code;
	logic [3:0] to_code;
	logic [3:0] to_eff;
	logic [9:0] delay_ticks;
	logic [9:0] timeout_ticks;
	logic [9:0] qual_ticks;
	logic checking;
	logic freq_low;
	logic freq_high;
	logic ended;
	logic clr_low;
	logic clr_high;

	// ------------------------------------------------------------------
	// Field extraction
	// ------------------------------------------------------------------
	assign enable = ctrl3[`RV_EN_BIT];
	assign ras = ctrl3[`RV_AS_MSB:0];
	assign max_frequency_bound = aux[`RV_MX_MSB:0];
	assign delay_code = {ctrl2[`RV_DLY_HI_BIT], aux[`RV_AUX_DLY_MSB:`RV_AUX_DLY_LSB]};
	assign to_code = ctrl2[`RV_TO_MSB:`RV_TO_LSB];
	// Invalid timeout code runs as the shortest step
	assign to_eff = (to_code == 4'h0) ? 4'h1 : to_code;
	assign delay_ticks = 10'(delay_code) * 10'(`RV_DELAY_STEP_MS / `RV_TICK_MS);
	assign timeout_ticks = 10'(to_eff) * 10'(`RV_TIMEOUT_STEP_MS / `RV_TICK_MS);
	assign qual_ticks = (10'(ctrl2[`RV_QI_MSB:0]) + 10'h001)
		* 10'(`RV_QUAL_STEP_MS / `RV_TICK_MS);

	// ------------------------------------------------------------------
	// Line event synchroniser and edge detect
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			sync3 <= 1'b0;
		end else begin
			sync1 <= ring_event_i;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	assign ev = sync2 & ~sync3;

	// ------------------------------------------------------------------
	// Wishbone slave
	// ------------------------------------------------------------------
	assign access = cyc_i & stb_i & ~ack_o;
	assign wr_en = access & we_i & sel_i[0];
	assign clr_low = wr_en & reg_hit(adr_i, `RV_IDX_STAT) & dat_i[`RV_ST_LOW];
	assign clr_high = wr_en & reg_hit(adr_i, `RV_IDX_STAT) & dat_i[`RV_ST_HIGH];

	always_comb begin
		rd_byte = 8'h00;
		if (reg_hit(adr_i, `RV_IDX_CTRL2)) begin
			rd_byte = ctrl2;
		end else if (reg_hit(adr_i, `RV_IDX_CTRL3)) begin
			// Reserved bit reads zero
			rd_byte = {ctrl3[`RV_EN_BIT], 1'b0, ras};
		end else if (reg_hit(adr_i, `RV_IDX_AUX)) begin
			rd_byte = aux;
		end else if (reg_hit(adr_i, `RV_IDX_STAT)) begin
			rd_byte[`RV_ST_VALID] = ring_valid;
			rd_byte[`RV_ST_LOW] = too_low;
			rd_byte[`RV_ST_HIGH] = too_high;
			rd_byte[`RV_ST_BUSY] = (state != ST_IDLE);
		end
	end

	always_comb begin
		next_ctrl2 = ctrl2;
		next_ctrl3 = ctrl3;
		next_aux = aux;
		next_ack = access;
		next_dat = 32'h0000_0000;
		if (access && !we_i) begin
			next_dat = {24'h00_0000, rd_byte};
		end
		if (wr_en && reg_hit(adr_i, `RV_IDX_CTRL2)) begin
			next_ctrl2 = dat_i[7:0];
		end
		if (wr_en && reg_hit(adr_i, `RV_IDX_CTRL3)) begin
			next_ctrl3 = {dat_i[`RV_EN_BIT], 1'b0, dat_i[`RV_AS_MSB:0]};
		end
		if (wr_en && reg_hit(adr_i, `RV_IDX_AUX)) begin
			next_aux = dat_i[7:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl2 <= `RV_CTRL2_RST;
			ctrl3 <= `RV_CTRL3_RST;
			aux <= `RV_AUX_RST;
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			ctrl2 <= next_ctrl2;
			ctrl3 <= next_ctrl3;
			aux <= next_aux;
			ack_o <= next_ack;
			dat_o <= next_dat;
		end
	end

	// ------------------------------------------------------------------
	// Qualification core
	// ------------------------------------------------------------------
	assign tick = (pre == 16'(TICK_CYCLES - 1));
	assign checking = enable & (state != ST_IDLE);
	assign freq_low = ev & checking & (qtimer == 6'h00);
	assign freq_high = ev & checking & (qtimer != 6'h00) & (qtimer > max_frequency_bound);
	assign ended = (state != ST_IDLE) & ~ev & (idle_cnt >= timeout_ticks);

	always_comb begin
		next_state = state;
		next_pre = tick ? 16'h0000 : pre + 16'h0001;
		next_qtimer = qtimer;
		next_phase = phase;
		next_idle_cnt = idle_cnt;
		if (tick && qtimer != 6'h00) begin
			next_qtimer = qtimer - 6'h01;
		end
		if (tick && idle_cnt != 10'h3ff) begin
			next_idle_cnt = idle_cnt + 10'h001;
		end
		if (tick && phase != 10'h3ff) begin
			next_phase = phase + 10'h001;
		end
		case (state)
			ST_IDLE: begin
				if (ev) begin
					// Bypass skips qualification and frequency checks
					next_state = enable ? ST_QUAL : ST_DELAY;
					next_phase = 10'h000;
				end
			end
			ST_QUAL: begin
				if (phase >= qual_ticks) begin
					next_state = ST_DELAY;
					next_phase = 10'h000;
				end
			end
			ST_DELAY: begin
				if (phase >= delay_ticks) begin
					next_state = ST_VALID;
				end
			end
			ST_VALID: begin
				next_state = ST_VALID;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
		if (ev) begin
			next_qtimer = ras;
			next_idle_cnt = 10'h000;
		end
		if (freq_low || freq_high || ended) begin
			next_state = ST_IDLE;
		end
		next_ring_valid = (next_state == ST_VALID);
		// Set wins over a software clear in the same cycle
		next_too_low = (too_low & ~clr_low) | freq_low;
		next_too_high = (too_high & ~clr_high) | freq_high;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= ST_IDLE;
			pre <= 16'h0000;
			qtimer <= 6'h00;
			phase <= 10'h000;
			idle_cnt <= 10'h000;
			ring_valid <= 1'b0;
			ring_valid_o <= 1'b0;
			too_low <= 1'b0;
			too_high <= 1'b0;
		end else begin
			state <= next_state;
			pre <= next_pre;
			qtimer <= next_qtimer;
			phase <= next_phase;
			idle_cnt <= next_idle_cnt;
			ring_valid <= next_ring_valid;
			ring_valid_o <= next_ring_valid;
			too_low <= next_too_low;
			too_high <= next_too_high;
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_start;
		state == ST_IDLE && ev;
	endsequence

	sequence s_low_event;
		ev && enable && state != ST_IDLE && qtimer == 6'h00;
	endsequence

	sequence s_high_event;
		ev && enable && state != ST_IDLE && qtimer != 6'h00 && qtimer > max_frequency_bound;
	endsequence

	sequence s_good_event;
		ev && !(enable && state != ST_IDLE && (qtimer == 6'h00 || qtimer > max_frequency_bound));
	endsequence

	bus_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
		else $error("bus request not answered in one cycle");

	valid_match_a: assert property (ring_valid_o == (state == ST_VALID))
		else $error("valid output disagrees with state");

	delay_hold_a: assert property (state == ST_DELAY && phase < delay_ticks |=> !ring_valid_o)
		else $error("valid ring reported before delay elapsed");

	timeout_end_a: assert property (
		state != ST_IDLE && !ev && idle_cnt >= timeout_ticks |=> state == ST_IDLE && !ring_valid_o)
		else $error("ringing not ended at timeout");

	qual_enter_a: assert property (s_start and enable |=> state == ST_QUAL)
		else $error("qualification not entered on first event");

	bypass_path_a: assert property (s_start and !enable |=> state == ST_DELAY)
		else $error("bypass did not skip qualification");

	timer_reload_a: assert property (s_good_event |=> qtimer == $past(ras))
		else $error("assertion timer not reloaded on event");

	too_low_a: assert property (s_low_event |=> state == ST_IDLE ##0 too_low)
		else $error("late event did not invalidate ring");

	too_high_a: assert property (s_high_event |=> state == ST_IDLE ##0 too_high)
		else $error("early event did not invalidate ring");

	spacing_ok_a: assert property (
		ev && enable && state == ST_QUAL && qtimer != 6'h00 && qtimer <= max_frequency_bound |=> state != ST_IDLE)
		else $error("event at legal spacing invalidated ring");

	reserved_zero_a: assert property (ctrl3[`RV_RES_BIT] == 1'b0)
		else $error("reserved bit stored as one");

endmodule : ring_validation_logic

/* sim/ring_line_model.sv */
// Line-side model producing periodic TIP/RING threshold events
`timescale 1ns/100ps

module ring_line_model (
	input wire logic clk_i,
	input wire logic run_i,
	input wire logic [15:0] gap_i,
	output logic ring_event_o
);
	logic [15:0] cnt;
	logic [15:0] next_cnt;

	// ----------------------------------------
	// Event spacing
	// ----------------------------------------
	always_comb begin
		next_cnt = (!run_i || cnt == gap_i - 16'h1) ? 16'h0 : cnt + 16'h1;
	end

	always_ff @(posedge clk_i) begin
		cnt <= next_cnt;
	end

	// Two-cycle pulse, then low for the rest of the gap
	assign ring_event_o = run_i && cnt < 16'h2;
endmodule : ring_line_model

/* sim/ring_validation_logic_tb.sv */
// Testbench for the ring validation logic
`timescale 1ns/100ps

module ring_validation_logic_tb;
	logic clk_i = 0;
	logic rst_i = 1;
	logic cyc = 0, stb = 0, we = 0, run = 0, ring_ev, ev_d = 0;
	logic [7:0] adr = 8'h0;
	logic [31:0] dat = 32'h0, rd, dat_o;
	logic [15:0] gap = 16'h4;
	logic ack_o, ring_valid_o;
	int bad_count = 0, n_tests = 0, since_ev = 0, n;

	ring_validation_logic #(.TICK_CYCLES(4)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
		.stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(dat), .dat_o(dat_o),
		.ack_o(ack_o), .ring_event_i(ring_ev), .ring_valid_o(ring_valid_o));
	ring_line_model line_u (.clk_i(clk_i), .run_i(run), .gap_i(gap), .ring_event_o(ring_ev));

	initial begin
		forever #25 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		ev_d <= ring_ev;
		since_ev <= (ring_ev && !ev_d) ? 0 : since_ev + 1;
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task finish_test;
		$display("counts: %0d compares, %0d mismatches", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : finish_test

	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		i = 0;
		do begin
			@(posedge clk_i);
			i++;
		end while (ack_o !== 1'b1 && i < 20);
		rd = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
		if (i >= 20) begin
			bad_count++;
			finish_test();
		end
	endtask : wb

	task wait_valid(input logic lvl, input int bound);
		n = 0;
		while (ring_valid_o !== lvl && n < bound) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= bound) begin
			bad_count++;
			finish_test();
		end
	endtask : wait_valid

	task range(input int v, input int lo, input int hi);
		check(v >= lo && v <= hi, 1'b1);
	endtask : range

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		wb(0, 8'h5c, 0); check(rd, 32'h2d);
		wb(0, 8'h60, 0); check(rd, 32'h19);
		wb(1, 8'hfc, 32'hff);
		wb(0, 8'hfc, 0); check(rd, 32'h0);
		$display("test registers done");
		// Bypass, delay code 1, timeout code 1, spacing too fast for validation
		wb(1, 8'h5c, 32'h08);
		wb(1, 8'h80, 32'h4d);
		gap <= 16'd16;
		run <= 1;
		wait_valid(1, 2000); range(n, 500, 530);
		run <= 0;
		wait_valid(0, 2000); range(since_ev, 252, 272);
		$display("test bypass done");
		// Bypass, delay code 5 through the high bit, invalid timeout code runs as 1
		wb(1, 8'h5c, 32'h80);
		run <= 1;
		wait_valid(1, 3000); range(n, 2555, 2575);
		run <= 0;
		wait_valid(0, 2000); range(since_ev, 252, 272);
		$display("test long delay done");
		// Validation on, qualification code 0, timeout code 2
		wb(1, 8'h80, 32'h0d);
		wb(1, 8'h5c, 32'h10);
		wb(1, 8'h60, 32'h99);
		gap <= 16'd72;
		run <= 1;
		wait_valid(1, 2000); range(n, 250, 284);
		wb(0, 8'h84, 0); check(rd[0], 1'b1);
		run <= 0;
		wait_valid(0, 2000); range(since_ev, 508, 528);
		$display("test qualify done");
		// Too high then too low
		gap <= 16'd16;
		run <= 1;
		repeat (400) @(posedge clk_i);
		check(ring_valid_o, 1'b0);
		wb(0, 8'h84, 0); check(rd & 32'h6, 32'h4);
		run <= 0;
		wb(1, 8'h84, 32'h6);
		wb(0, 8'h84, 0); check(rd & 32'h6, 32'h0);
		gap <= 16'd160;
		run <= 1;
		repeat (700) @(posedge clk_i);
		check(ring_valid_o, 1'b0);
		wb(0, 8'h84, 0); check(rd & 32'h6, 32'h2);
		run <= 0;
		$display("test errors done");
		finish_test();
	end
endmodule : ring_validation_logic_tb
